// *** verilog/osms_seq.sv ***
// Measurement sequencer: APB registers, forced and autonomous runs, results
//
// Summary of operation
// - Host command starts one proximity or ambient measurement.
// - Autonomous mode repeats at programmed interval, interrupting after each.
// - Each proximity cycle runs up to three conversions enabled in list.
// - Each proximity conversion has its own LED selection, default single LED.
// - Interrupt may be raised after the enabled proximity set completes.
// - Each LED current is programmable independently, changeable while running.
// - ADC offers low sensitive range and high range for bright light.
// - Saturated conversion loads all ones and flags overflow in response.
// - Result overflow value does not persist; later conversions write normally.
// - Response overflow stays latched until a no-operation command.
// - Commands still accepted and run while overflow is flagged.
// - Ambient infrared conversion skipped when its list bit is clear.
// - Ambient visible and infrared reported as separate result channels.
// - Every result is an unsigned sixteen bit value.
// - Integration time defaults to 25.6 us, programmable up to 3.28 ms.
// - Visible and infrared integration times programmed independently.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "osms_defs.svh"
package osms_pkg;
  typedef enum logic [2:0] {
    OSMS_IDLE  = 3'b000,
    OSMS_PROX  = 3'b001,
    OSMS_VIS   = 3'b010,
    OSMS_IR    = 3'b011,
    OSMS_WAIT  = 3'b100,
    OSMS_DONE  = 3'b101
  } osms_state_e;
endpackage : osms_pkg

module osms_seq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [16:0] adc_sample,
  output logic [2:0]       led_on,
  output logic [11:0]      led_current,
  output logic             meas_irq
);
  osms_pkg::osms_state_e state;
  osms_pkg::osms_state_e next_state;
  logic [7:0]  response;
  logic [7:0]  channel_enable_list;
  logic [11:0] ledsel;
  logic [7:0]  adccfg;
  logic [15:0] rate;
  logic        auto_on;
  logic        do_prox;
  logic        do_als;
  logic [1:0]  pidx;
  logic [15:0] rate_cnt;
  logic [15:0] vis_res;
  logic [15:0] ir_res;
  logic [15:0] prox_res [3];
  logic        conv_start;
  logic        conv_done;
  logic [15:0] conv_res;
  logic        conv_ovf;
  logic [2:0]  conv_tint;
  logic        wr_en;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic        addr_ok;

  // ----------------------------------------
  // APB slave decode
  // ----------------------------------------
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign cmd_wr  = wr_en && paddr == `OSMS_OFF_CMD;
  assign cmd     = pwdata[7:0];
  assign addr_ok = paddr <= `OSMS_OFF_PROX2 && paddr[1:0] == 2'b00;
  assign pslverr = psel && penable && !addr_ok;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_enable_list      <= `OSMS_CHANNEL_ENABLE_LIST_RST;
      ledsel      <= `OSMS_LEDSEL_RST;
      led_current <= `OSMS_LEDCUR_RST;
      adccfg      <= `OSMS_ADCCFG_RST;
      rate        <= `OSMS_RATE_RST;
    end
    else if (wr_en)
    begin
      if (paddr == `OSMS_OFF_CHANNEL_ENABLE_LIST)
        channel_enable_list <= pwdata[7:0];
      else if (paddr == `OSMS_OFF_LEDSEL)
        ledsel <= pwdata[11:0];
      else if (paddr == `OSMS_OFF_LEDCUR)
        led_current <= pwdata[11:0];
      else if (paddr == `OSMS_OFF_ADCCFG)
        adccfg <= pwdata[7:0];
      else if (paddr == `OSMS_OFF_RATE)
        rate <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == `OSMS_OFF_RESPONSE)
        prdata <= {24'h000000, response};
      else if (paddr == `OSMS_OFF_CHANNEL_ENABLE_LIST)
        prdata <= {24'h000000, channel_enable_list};
      else if (paddr == `OSMS_OFF_LEDSEL)
        prdata <= {20'h00000, ledsel};
      else if (paddr == `OSMS_OFF_LEDCUR)
        prdata <= {20'h00000, led_current};
      else if (paddr == `OSMS_OFF_ADCCFG)
        prdata <= {24'h000000, adccfg};
      else if (paddr == `OSMS_OFF_RATE)
        prdata <= {16'h0000, rate};
      else if (paddr == `OSMS_OFF_STATUS)
        prdata <= {27'h0000000, auto_on, 1'b0, state};
      else if (paddr == `OSMS_OFF_VIS)
        prdata <= {16'h0000, vis_res};
      else if (paddr == `OSMS_OFF_IR)
        prdata <= {16'h0000, ir_res};
      else if (paddr == `OSMS_OFF_PROX0)
        prdata <= {16'h0000, prox_res[0]};
      else if (paddr == `OSMS_OFF_PROX1)
        prdata <= {16'h0000, prox_res[1]};
      else if (paddr == `OSMS_OFF_PROX2)
        prdata <= {16'h0000, prox_res[2]};
      else
        prdata <= 32'h00000000;
    end
  end
  // ----------------------------------------
  // Command handling and overflow latch
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      response <= 8'h00;
    else if (conv_done && conv_ovf)
      response[`OSMS_RESP_OVF] <= 1'b1;
    else if (cmd_wr && cmd == `OSMS_CMD_NOP)
      response <= 8'h00;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_on <= 1'b0;
      do_prox <= 1'b0;
      do_als  <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (cmd == `OSMS_CMD_AUTO_START)
        auto_on <= 1'b1;
      else if (cmd == `OSMS_CMD_AUTO_STOP)
        auto_on <= 1'b0;
      if (state == osms_pkg::OSMS_IDLE || state == osms_pkg::OSMS_WAIT)
      begin
        do_prox <= cmd == `OSMS_CMD_PROX_FORCE || cmd == `OSMS_CMD_BOTH_FORCE ||
                   cmd == `OSMS_CMD_AUTO_START;
        do_als  <= cmd == `OSMS_CMD_ALS_FORCE || cmd == `OSMS_CMD_BOTH_FORCE ||
                   cmd == `OSMS_CMD_AUTO_START;
      end
    end
    else if (state == osms_pkg::OSMS_WAIT && rate_cnt == 16'h0000)
    begin
      do_prox <= 1'b1;
      do_als  <= 1'b1;
    end
    else if (state == osms_pkg::OSMS_DONE)
    begin
      do_prox <= 1'b0;
      do_als  <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  function automatic logic [1:0] osms_next_prox(input logic [1:0] from, input logic [7:0] l);
    logic [1:0] n;
    n = 2'd3;
    for (int i = 2; i >= 0; i--)
      if (l[i] && 2'(i) >= from)
        n = 2'(i);
    return n;
  endfunction : osms_next_prox
  always_comb
  begin
    next_state = state;
    case (state)
      osms_pkg::OSMS_IDLE, osms_pkg::OSMS_WAIT:
        if (do_prox && osms_next_prox(2'd0, channel_enable_list) != 2'd3)
          next_state = osms_pkg::OSMS_PROX;
        else if (do_als && channel_enable_list[`OSMS_CH_VIS])
          next_state = osms_pkg::OSMS_VIS;
        else if (do_als && channel_enable_list[`OSMS_CH_IR])
          next_state = osms_pkg::OSMS_IR;
        else if (do_prox || do_als)
          next_state = osms_pkg::OSMS_DONE;
        else if (auto_on)
          next_state = osms_pkg::OSMS_WAIT;
        else
          next_state = osms_pkg::OSMS_IDLE;
      osms_pkg::OSMS_PROX:
        if (conv_done && pidx != 2'd2 && osms_next_prox(pidx + 2'd1, channel_enable_list) != 2'd3)
          next_state = osms_pkg::OSMS_PROX;
        else if (conv_done && do_als && channel_enable_list[`OSMS_CH_VIS])
          next_state = osms_pkg::OSMS_VIS;
        else if (conv_done && do_als && channel_enable_list[`OSMS_CH_IR])
          next_state = osms_pkg::OSMS_IR;
        else if (conv_done)
          next_state = osms_pkg::OSMS_DONE;
      osms_pkg::OSMS_VIS:
        if (conv_done)
          next_state = channel_enable_list[`OSMS_CH_IR] ? osms_pkg::OSMS_IR : osms_pkg::OSMS_DONE;
      osms_pkg::OSMS_IR:
        if (conv_done)
          next_state = osms_pkg::OSMS_DONE;
      osms_pkg::OSMS_DONE:
        next_state = auto_on ? osms_pkg::OSMS_WAIT : osms_pkg::OSMS_IDLE;
      default:
        next_state = osms_pkg::OSMS_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= osms_pkg::OSMS_IDLE;
      pidx  <= 2'd0;
    end
    else
    begin
      state <= next_state;
      if (next_state == osms_pkg::OSMS_PROX && (state != osms_pkg::OSMS_PROX || conv_done))
        pidx <= osms_next_prox(state == osms_pkg::OSMS_PROX ? pidx + 2'd1 : 2'd0, channel_enable_list);
    end
  end
  // Interval counter reloads on every run so autonomous runs keep spacing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rate_cnt <= 16'h0000;
    else if (state == osms_pkg::OSMS_DONE)
      rate_cnt <= rate;
    else if (state == osms_pkg::OSMS_WAIT && rate_cnt != 16'h0000)
      rate_cnt <= rate_cnt - 16'h0001;
  end
  // Conversion start pulses in the first cycle of entering or re-entering a step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_start <= 1'b0;
    else
      conv_start <= (next_state == osms_pkg::OSMS_PROX || next_state == osms_pkg::OSMS_VIS ||
                     next_state == osms_pkg::OSMS_IR) && (next_state != state || conv_done);
  end
  assign conv_tint = state == osms_pkg::OSMS_IR ? adccfg[6:4] : adccfg[2:0];
  assign led_on    = state == osms_pkg::OSMS_PROX ? ledsel[pidx*4 +: 3] : 3'b000;
  osms_conv u_conv (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (conv_start),
    .tint_sel   (conv_tint),
    .high_range (state == osms_pkg::OSMS_PROX ? adccfg[3] : adccfg[7]),
    .adc_sample (adc_sample),
    .done       (conv_done),
    .result     (conv_res),
    .ovf        (conv_ovf)
  );
  // ----------------------------------------
  // Results and completion event
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vis_res  <= 16'h0000;
      ir_res   <= 16'h0000;
      prox_res <= '{16'h0000, 16'h0000, 16'h0000};
    end
    else if (conv_done)
    begin
      if (state == osms_pkg::OSMS_VIS)
        vis_res <= conv_res;
      else if (state == osms_pkg::OSMS_IR)
        ir_res <= conv_res;
      else if (state == osms_pkg::OSMS_PROX)
        prox_res[pidx] <= conv_res;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      meas_irq <= 1'b0;
    else
      meas_irq <= state == osms_pkg::OSMS_DONE;
  end
  a_ovf_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_done && conv_ovf) |=> response[`OSMS_RESP_OVF])
    else $error("overflow not latched");
  a_ovf_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (response[`OSMS_RESP_OVF] && !(cmd_wr && cmd == `OSMS_CMD_NOP)) |=>
    response[`OSMS_RESP_OVF])
    else $error("overflow cleared without no-op");
  a_ir_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (state == osms_pkg::OSMS_VIS && conv_done && !channel_enable_list[`OSMS_CH_IR]) |=>
    state == osms_pkg::OSMS_DONE)
    else $error("infrared not skipped");
  a_irq_done: assert property (@(posedge pclk) disable iff (!presetn)
    state == osms_pkg::OSMS_DONE |=> meas_irq)
    else $error("no interrupt after run");
  a_force_run: assert property (@(posedge pclk) disable iff (!presetn)
    (state == osms_pkg::OSMS_IDLE && cmd_wr && cmd == `OSMS_CMD_BOTH_FORCE) |=>
    ##[1:2] state != osms_pkg::OSMS_IDLE)
    else $error("forced run not started");
  a_res_update: assert property (@(posedge pclk) disable iff (!presetn)
    (!conv_done) |=> $stable(vis_res) && $stable(ir_res))
    else $error("result changed mid conversion");
  a_led_idle: assert property (@(posedge pclk) disable iff (!presetn)
    state != osms_pkg::OSMS_PROX |-> led_on == 3'b000)
    else $error("led on outside proximity");
  a_prox_list: assert property (@(posedge pclk) disable iff (!presetn)
    state == osms_pkg::OSMS_PROX |-> channel_enable_list[pidx])
    else $error("disabled proximity conversion run");
endmodule : osms_seq

// *** verilog/osms_defs.svh ***
// Offsets, field positions, reset values and timing counts of the measurement sequencer
`ifndef OSMS_DEFS_SVH
`define OSMS_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OSMS_OFF_CMD        12'h000
`define OSMS_OFF_RESPONSE   12'h004
`define OSMS_OFF_CHANNEL_ENABLE_LIST     12'h008
`define OSMS_OFF_LEDSEL     12'h00C
`define OSMS_OFF_LEDCUR     12'h010
`define OSMS_OFF_ADCCFG     12'h014
`define OSMS_OFF_RATE       12'h018
`define OSMS_OFF_STATUS     12'h01C
`define OSMS_OFF_VIS        12'h020
`define OSMS_OFF_IR         12'h024
`define OSMS_OFF_PROX0      12'h028
`define OSMS_OFF_PROX1      12'h02C
`define OSMS_OFF_PROX2      12'h030
// ----------------------------------------
// Commands
// ----------------------------------------
`define OSMS_CMD_NOP        8'h00
`define OSMS_CMD_PROX_FORCE 8'h05
`define OSMS_CMD_ALS_FORCE  8'h06
`define OSMS_CMD_BOTH_FORCE 8'h07
`define OSMS_CMD_AUTO_START 8'h0F
`define OSMS_CMD_AUTO_STOP  8'h0B
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define OSMS_CH_PROX0       0
`define OSMS_CH_PROX1       1
`define OSMS_CH_PROX2       2
`define OSMS_CH_VIS         4
`define OSMS_CH_IR          5
`define OSMS_RESP_OVF       7
`define OSMS_CHANNEL_ENABLE_LIST_RST     8'h31
`define OSMS_LEDSEL_RST     12'h421
`define OSMS_LEDCUR_RST     12'h333
`define OSMS_ADCCFG_RST     8'h00
`define OSMS_RATE_RST       16'h0100
`define OSMS_RESULT_OVF     16'hFFFF
// ----------------------------------------
// Timing: integration 25.6 us base, steps doubling up to 3.28 ms
// ----------------------------------------
`define OSMS_TINT_NS        25600
`define OSMS_CLK_NS         100
`define OSMS_TINT_CYC       ((`OSMS_TINT_NS + `OSMS_CLK_NS - 1) / `OSMS_CLK_NS)
`define OSMS_TINT_MAXSH     7
`endif

// *** verilog/osms_conv.sv ***
// One ADC conversion: integration timing and overflow detection
`timescale 1ns/1ns
`include "osms_defs.svh"
module osms_conv #(
  parameter int unsigned BASE_CYC = `OSMS_TINT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [2:0]  tint_sel,
  input  wire logic        high_range,
  input  wire logic [16:0] adc_sample,
  output logic             done,
  output logic [15:0]      result,
  output logic             ovf
);
  logic [15:0] cnt;
  logic        busy;

  // ----------------------------------------
  // Integration counter: base time shifted by tint_sel
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= 16'h0000;
      busy <= 1'b0;
    end
    else if (start && !busy)
    begin
      cnt  <= 16'((BASE_CYC << tint_sel) - 1);
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (cnt == 16'h0000)
        busy <= 1'b0;
      else
        cnt <= cnt - 16'h0001;
    end
  end

  // Saturation: low range clips at 16 bits, high range divides by 2 first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done   <= 1'b0;
      result <= 16'h0000;
      ovf    <= 1'b0;
    end
    else
    begin
      done <= busy && (cnt == 16'h0000);
      if (busy && cnt == 16'h0000)
      begin
        if (high_range)
        begin
          result <= adc_sample[16:1];
          ovf    <= 1'b0;
        end
        else if (adc_sample[16])
        begin
          result <= `OSMS_RESULT_OVF;
          ovf    <= 1'b1;
        end
        else
        begin
          result <= adc_sample[15:0];
          ovf    <= 1'b0;
        end
      end
    end
  end

  a_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy && tint_sel == 3'd0) |-> ##(BASE_CYC + 1) done)
    else $error("conversion length wrong");
endmodule : osms_conv

// *** verif/osms_adc_model.sv ***
// Light source and ADC front end seen by the sequencer
`timescale 1ns/1ns
module osms_adc_model (
  input  wire logic [2:0]  led_on,
  input  wire logic [16:0] light_level,
  output logic      [16:0] adc_sample
);
  // -----------------------------
  // Reflected LED light adds the enable code, so each LED choice is told apart
  // -----------------------------
  assign adc_sample = light_level + {14'h0000, led_on};
endmodule : osms_adc_model

// *** verif/osms_seq_bench.sv ***
// Self-checking bench of the measurement sequencer
`timescale 1ns/1ns
`include "osms_defs.svh"
module osms_seq_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [16:0] adc_sample;
  logic [16:0] light;
  logic [2:0]  led_on;
  logic [11:0] led_current;
  logic        meas_irq;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          checked;
  int          irqs;
  int          c0;
  int          c1;
  logic [11:0] row_addr [8] = '{`OSMS_OFF_CHANNEL_ENABLE_LIST, `OSMS_OFF_LEDSEL, `OSMS_OFF_LEDCUR,
    `OSMS_OFF_ADCCFG, `OSMS_OFF_RATE, `OSMS_OFF_RESPONSE, `OSMS_OFF_STATUS, `OSMS_OFF_VIS};
  logic [31:0] row_val [8] = '{32'h00000031, 32'h00000421, 32'h00000333, 32'h00000000,
    32'h00000100, 32'h00000000, 32'h00000000, 32'h00000000};

  osms_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_sample(adc_sample), .led_on(led_on),
    .led_current(led_current), .meas_irq(meas_irq));
  osms_adc_model adc (.led_on(led_on), .light_level(light), .adc_sample(adc_sample));

  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (meas_irq === 1'b1) irqs <= irqs + 1;
  end

  // -----------------------------
  // Shared tasks
  // -----------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      print_verdict();
    end
    @(posedge pclk);
  endtask : apb

  task run(input logic [7:0] c, output int cyc);
    apb(1'b1, `OSMS_OFF_CMD, {24'h000000, c});
    cyc = 0;
    do
    begin
      @(posedge pclk);
      #1;
      cyc++;
    end while (meas_irq !== 1'b1 && cyc < 40000);
    @(posedge pclk);
    if (cyc >= 40000)
    begin
      errors++;
      print_verdict();
    end
  endtask : run

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rdchk

  // -----------------------------
  // Main sequence
  // -----------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    light = 17'h00000;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(row_addr[i], row_val[i]);
    check({20'h00000, led_current}, 32'h00000333);
    apb(1'b0, 12'h034, 32'h00000000);
    check({31'h0, er}, 32'h00000001);
    check(rd, 32'h00000000);
    check({31'h0, pready}, 32'h00000001);
    $display("test reset_and_map done");
    apb(1'b1, `OSMS_OFF_LEDCUR, 32'h000005A7);
    check({20'h00000, led_current}, 32'h000005A7);
    light <= 17'h01234;
    apb(1'b1, `OSMS_OFF_CHANNEL_ENABLE_LIST, 32'h00000037);
    run(`OSMS_CMD_PROX_FORCE, c0);
    for (int i = 0; i < 3; i++)
      rdchk(`OSMS_OFF_PROX0 + 12'(4 * i), 32'h00001234 + (32'h1 << i));
    apb(1'b1, `OSMS_OFF_LEDSEL, 32'h00000124);
    run(`OSMS_CMD_PROX_FORCE, c0);
    rdchk(`OSMS_OFF_PROX0, 32'h00001238);
    rdchk(`OSMS_OFF_PROX2, 32'h00001235);
    light <= 17'h00ABC;
    apb(1'b1, `OSMS_OFF_CHANNEL_ENABLE_LIST, 32'h00000031);
    run(`OSMS_CMD_BOTH_FORCE, c0);
    rdchk(`OSMS_OFF_PROX1, 32'h00001236);
    rdchk(`OSMS_OFF_VIS, 32'h00000ABC);
    $display("test proximity done");
    light <= 17'h00777;
    run(`OSMS_CMD_ALS_FORCE, c0);
    rdchk(`OSMS_OFF_IR, 32'h00000777);
    apb(1'b1, `OSMS_OFF_CHANNEL_ENABLE_LIST, 32'h00000010);
    light <= 17'h00555;
    run(`OSMS_CMD_ALS_FORCE, c0);
    rdchk(`OSMS_OFF_VIS, 32'h00000555);
    rdchk(`OSMS_OFF_IR, 32'h00000777);
    $display("test ambient done");
    light <= 17'h10000;
    run(`OSMS_CMD_ALS_FORCE, c0);
    rdchk(`OSMS_OFF_VIS, 32'h0000FFFF);
    rdchk(`OSMS_OFF_RESPONSE, 32'h00000080);
    light <= 17'h00321;
    run(`OSMS_CMD_ALS_FORCE, c0);
    rdchk(`OSMS_OFF_VIS, 32'h00000321);
    rdchk(`OSMS_OFF_RESPONSE, 32'h00000080);
    apb(1'b1, `OSMS_OFF_CMD, {24'h000000, `OSMS_CMD_NOP});
    rdchk(`OSMS_OFF_RESPONSE, 32'h00000000);
    apb(1'b1, `OSMS_OFF_ADCCFG, 32'h00000080);
    light <= 17'h10000;
    run(`OSMS_CMD_ALS_FORCE, c0);
    rdchk(`OSMS_OFF_VIS, 32'h00008000);
    rdchk(`OSMS_OFF_RESPONSE, 32'h00000000);
    $display("test overflow_and_range done");
    light <= 17'h00100;
    apb(1'b1, `OSMS_OFF_ADCCFG, 32'h00000000);
    run(`OSMS_CMD_ALS_FORCE, c0);
    apb(1'b1, `OSMS_OFF_ADCCFG, 32'h00000007);
    run(`OSMS_CMD_ALS_FORCE, c1);
    check(32'(c1 - c0), 32'd32512);
    apb(1'b1, `OSMS_OFF_CHANNEL_ENABLE_LIST, 32'h00000020);
    run(`OSMS_CMD_ALS_FORCE, c1);
    check(32'(c1), 32'(c0));
    apb(1'b1, `OSMS_OFF_ADCCFG, 32'h00000030);
    run(`OSMS_CMD_ALS_FORCE, c1);
    check(32'(c1 - c0), 32'd1792);
    $display("test integration done");
    apb(1'b1, `OSMS_OFF_ADCCFG, 32'h00000000);
    apb(1'b1, `OSMS_OFF_RATE, 32'h00000014);
    apb(1'b1, `OSMS_OFF_CMD, {24'h000000, `OSMS_CMD_AUTO_START});
    c0 = irqs;
    repeat (1000) @(posedge pclk);
    check({31'h0, irqs - c0 >= 3}, 32'h00000001);
    apb(1'b1, `OSMS_OFF_CMD, {24'h000000, `OSMS_CMD_AUTO_STOP});
    repeat (400) @(posedge pclk);
    c0 = irqs;
    repeat (600) @(posedge pclk);
    check(32'(irqs - c0), 32'd0);
    $display("test autonomous done");
    print_verdict();
  end
endmodule : osms_seq_bench
